/* mps_defines.vh */
// constants for the multiphase pwm sequencer
// assumes a 250 MHz single clock; times are turned into cycle counts here
`ifndef MPS_DEFINES_VH
`define MPS_DEFINES_VH
`define MPS_CLK_MHZ 250
`define MPS_PERIOD_W 16
`define MPS_PERIOD_DEF 16'd250
`define MPS_PERIOD_MIN 16'd6
`define MPS_RST_HOLD_MS 50
`define MPS_RST_HOLD_CYC (`MPS_RST_HOLD_MS * 1000 * `MPS_CLK_MHZ)
`define MPS_HOLD_W 24
`define MPS_ST_NORMAL 2'd0
`define MPS_ST_LOWPWR 2'd1
`define MPS_ST_WAIT 2'd2
`endif

/* mps_phase_cell.v */
// one phase of the pulse decision and gate drive
// assumes the comparator and zero-current inputs are synchronous to i_clk
module mps_phase_cell (
	input wire i_clk,
	input wire i_arst_n,
	input wire i_enable,
	input wire i_interval_start,
	input wire i_cmp_above,
	input wire i_force_on,
	input wire i_diode_emulation_mode,
	input wire i_zero_current,
	output reg o_pwm,
	output reg o_high_side_gate,
	output reg o_low_side_gate
);
	reg fired_q;
	reg pwm_d;
	reg fired_d;
	reg dem_off_q;
	always @* begin
		pwm_d = o_pwm;
		fired_d = fired_q;
		if (i_interval_start)
			fired_d = 1'b0;
		if (!i_enable) begin
			pwm_d = 1'b0;
		end else if (i_force_on) begin
			pwm_d = 1'b1;
		end else if (o_pwm) begin
			if (!i_cmp_above)
				pwm_d = 1'b0;
		end else if (i_cmp_above && !fired_d) begin
			pwm_d = 1'b1;
			fired_d = 1'b1;
		end
	end
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_pwm <= 1'b0;
			fired_q <= 1'b0;
			dem_off_q <= 1'b0;
			o_high_side_gate <= 1'b0;
			o_low_side_gate <= 1'b0;
		end else begin
			o_pwm <= pwm_d;
			fired_q <= fired_d;
			// zero current parks both gates until next pulse
			if (!i_diode_emulation_mode || pwm_d)
				dem_off_q <= 1'b0;
			else if (i_zero_current)
				dem_off_q <= 1'b1;
			o_high_side_gate <= i_enable && pwm_d;
			o_low_side_gate <= i_enable && !pwm_d && !(dem_off_q || (i_diode_emulation_mode && i_zero_current));
		end
	end
endmodule // mps_phase_cell

/* mps_sequencer.v */
// top of the multiphase pwm sequencer: interval timing, phase count, power state
// assumes inputs synchronous to i_clk; comparators and current sense are analog outside
`include "mps_defines.vh"
module mps_sequencer #(
	parameter RST_HOLD_CYC = `MPS_RST_HOLD_CYC,
	parameter HAS_DRIVE_REDUCTION = 1,
	parameter HAS_PROC_RESET = 1
) (
	input wire i_clk,
	input wire i_arst_n,
	input wire [`MPS_PERIOD_W-1:0] i_switch_freq_set,
	input wire [2:0] i_cmp_above,
	input wire i_transient_all_phase_trip,
	input wire i_phase_three_sense_neg,
	input wire i_power_state_request_n,
	input wire i_soft_start_busy,
	input wire i_vid_transition_busy,
	input wire i_processor_reset_in_n,
	input wire [2:0] i_zero_current,
	output reg [2:0] o_pwm,
	output reg [2:0] o_high_side_gate,
	output reg [2:0] o_low_side_gate,
	output reg o_low_power_state,
	output reg o_diode_emulation_mode,
	output reg o_low_side_drive_reduction,
	output reg [2:0] o_interval_start
);
	localparam ST_NORMAL = `MPS_ST_NORMAL;
	localparam ST_LOWPWR = `MPS_ST_LOWPWR;
	localparam ST_WAIT = `MPS_ST_WAIT;
	localparam integer HOLD_LAST_I = RST_HOLD_CYC - 1;
	localparam [`MPS_HOLD_W-1:0] HOLD_LAST = HOLD_LAST_I[`MPS_HOLD_W-1:0];
	reg [`MPS_PERIOD_W-1:0] cnt_q;
	reg [`MPS_PERIOD_W-1:0] period_q;
	reg [`MPS_PERIOD_W-1:0] third_q;
	reg [`MPS_PERIOD_W-1:0] half_q;
	reg two_phase_q;
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [`MPS_HOLD_W-1:0] hold_q;
	reg busy_q;
	reg [2:0] start;
	reg [2:0] enable;
	reg lp_d;
	wire busy;
	wire [`MPS_PERIOD_W-1:0] per_clip;
	wire [2:0] cell_pwm;
	wire [2:0] cell_hg;
	wire [2:0] cell_lg;
	assign busy = i_soft_start_busy | i_vid_transition_busy;
	assign per_clip = (i_switch_freq_set < `MPS_PERIOD_MIN) ? `MPS_PERIOD_MIN : i_switch_freq_set;
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt_q <= {`MPS_PERIOD_W{1'b0}};
			period_q <= `MPS_PERIOD_DEF;
			third_q <= `MPS_PERIOD_DEF / 2'd3;
			half_q <= `MPS_PERIOD_DEF >> 1;
		end else if (cnt_q >= period_q - 1'b1) begin
			// period change takes effect only on wrap, keeping phases aligned
			cnt_q <= {`MPS_PERIOD_W{1'b0}};
			period_q <= per_clip;
			third_q <= per_clip / 2'd3;
			half_q <= per_clip >> 1;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
	// phase count strap, sampled while soft-start is busy
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			two_phase_q <= 1'b0;
		else if (i_soft_start_busy)
			two_phase_q <= i_phase_three_sense_neg;
	end
	always @* begin
		start[0] = (cnt_q == {`MPS_PERIOD_W{1'b0}});
		start[1] = two_phase_q ? (cnt_q == half_q) : (cnt_q == third_q);
		start[2] = !two_phase_q && (cnt_q == (third_q << 1));
	end
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_NORMAL: begin
				if (HAS_PROC_RESET && !i_processor_reset_in_n)
					state_d = ST_WAIT;
				else if (!busy && !busy_q && !i_power_state_request_n)
					state_d = ST_LOWPWR;
			end
			ST_LOWPWR: begin
				if (HAS_PROC_RESET && !i_processor_reset_in_n)
					state_d = ST_WAIT;
				else if (busy || i_power_state_request_n)
					state_d = ST_NORMAL;
			end
			ST_WAIT: begin
				if (i_processor_reset_in_n && hold_q >= HOLD_LAST)
					state_d = ST_NORMAL;
			end
			default: state_d = ST_NORMAL;
		endcase
	end
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_q <= ST_NORMAL;
			hold_q <= {`MPS_HOLD_W{1'b0}};
			busy_q <= 1'b1;
		end else begin
			state_q <= state_d;
			busy_q <= busy;
			// hold count restarts while reset low
			if (!i_processor_reset_in_n || state_q != ST_WAIT)
				hold_q <= {`MPS_HOLD_W{1'b0}};
			else if (hold_q < HOLD_LAST)
				hold_q <= hold_q + 1'b1;
		end
	end
	always @* begin
		lp_d = (state_d == ST_LOWPWR);
		enable[0] = 1'b1;
		enable[1] = !lp_d;
		enable[2] = !lp_d && !two_phase_q;
	end
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_phase
			mps_phase_cell u_cell (
				.i_clk(i_clk),
				.i_arst_n(i_arst_n),
				.i_enable(enable[g]),
				.i_interval_start(start[g]),
				.i_cmp_above(i_cmp_above[g]),
				.i_force_on(i_transient_all_phase_trip),
				.i_diode_emulation_mode(lp_d && (HAS_DRIVE_REDUCTION != 0) && (g == 0)),
				.i_zero_current(i_zero_current[g]),
				.o_pwm(cell_pwm[g]),
				.o_high_side_gate(cell_hg[g]),
				.o_low_side_gate(cell_lg[g])
			);
		end
	endgenerate
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_pwm <= 3'h0;
			o_high_side_gate <= 3'h0;
			o_low_side_gate <= 3'h0;
			o_low_power_state <= 1'b0;
			o_diode_emulation_mode <= 1'b0;
			o_low_side_drive_reduction <= 1'b0;
			o_interval_start <= 3'h0;
		end else begin
			o_pwm <= cell_pwm;
			o_high_side_gate <= cell_hg;
			o_low_side_gate <= cell_lg;
			o_low_power_state <= (state_q == ST_LOWPWR);
			o_diode_emulation_mode <= (state_q == ST_LOWPWR) && (HAS_DRIVE_REDUCTION != 0);
			o_low_side_drive_reduction <= (state_q == ST_LOWPWR) && (HAS_DRIVE_REDUCTION != 0);
			o_interval_start <= start;
		end
	end
endmodule // mps_sequencer

/* mps_sequencer_checker.sv */
// port checker for the sequencer
// assumes a 12-cycle switching period once running
module mps_sequencer_checker #(parameter HAS_DRIVE_REDUCTION = 1) (
	input wire logic i_clk, i_arst_n, i_transient_all_phase_trip, i_power_state_request_n,
	input wire logic i_soft_start_busy, i_vid_transition_busy, i_processor_reset_in_n,
	input wire logic o_low_power_state, o_diode_emulation_mode,
	input wire logic [2:0] i_cmp_above, i_zero_current, o_pwm, o_high_side_gate, o_low_side_gate, o_interval_start
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	sequence s_two_wraps;
		o_interval_start[0] ##12 o_interval_start[0];
	endsequence
	gate_excl_a: assert property ((o_high_side_gate & o_low_side_gate) == 3'h0) else $error("gates overlap");
	high_follow_a: assert property (o_high_side_gate == o_pwm) else $error("high gate off pulse");
	low_on_a: assert property ($past(i_arst_n) && $past(i_arst_n, 2) && !o_pwm[0] && !o_diode_emulation_mode
		&& !$past(o_diode_emulation_mode) |-> o_low_side_gate[0]) else $error("low gate off");
	trip_force_a: assert property (i_transient_all_phase_trip |-> ##2 o_pwm[0]) else $error("trip ignored");
	pwm_fall_a: assert property ((!i_cmp_above[0] && !i_transient_all_phase_trip) [*2] |-> ##1 !o_pwm[0])
		else $error("pulse stuck high");
	stagger_a: assert property (s_two_wraps |-> (##4 o_interval_start[1]) or (##6 o_interval_start[1]))
		else $error("phase stagger");
	low_phase_a: assert property (o_low_power_state [*3] |-> o_pwm[2:1] == 2'b00) else $error("extra phase");
	dem_mode_a: assert property (o_low_power_state [*2] |-> o_diode_emulation_mode == (HAS_DRIVE_REDUCTION != 0))
		else $error("variant mode");
	normal_force_a: assert property (i_power_state_request_n || i_soft_start_busy || i_vid_transition_busy
		|| !i_processor_reset_in_n |-> ##2 !o_low_power_state) else $error("low power not blocked");
	zero_off_a: assert property (o_diode_emulation_mode && i_zero_current[0] && !o_pwm[0] && !i_cmp_above[0]
		&& !i_transient_all_phase_trip |-> ##[1:2] !o_low_side_gate[0]) else $error("no zero cutoff");
endmodule // mps_sequencer_checker
bind mps_sequencer mps_sequencer_checker #(.HAS_DRIVE_REDUCTION(HAS_DRIVE_REDUCTION)) chk (.*);

/* mps_far_model.sv */
// far side: processor request pin and phase inductor current
// assumes current drains to zero after two low-gate cycles
module mps_far_model (
	input wire logic i_clk,
	input wire logic i_want_low,
	input wire logic [2:0] i_low_side_gate,
	output logic o_request_n = 1'b1,
	output logic [2:0] o_zero_current = 3'h0
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [2:0] low_q = 3'h0;
	// output changes land just after the edge, never on it
	always @(posedge i_clk) begin
		low_q <= i_low_side_gate;
		o_request_n <= #1 !i_want_low;
		o_zero_current <= #1 low_q & i_low_side_gate;
	end
endmodule // mps_far_model

/* multiphase_pwm_sequencer_tb_top.sv */
// bench: interval timing, pulse gating, trip, phase count, power state
// assumes a 12-cycle period and a short reset-hold count
module multiphase_pwm_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_clk = 0, i_arst_n = 0, i_transient_all_phase_trip = 0, i_phase_three_sense_neg = 0;
	logic i_soft_start_busy = 1, i_vid_transition_busy = 0, i_processor_reset_in_n = 1, want_low = 0;
	logic [15:0] i_switch_freq_set = 16'h000c;
	logic [2:0] i_cmp_above = 3'h0, i_zero_current, o_pwm, o_high_side_gate, o_low_side_gate, o_interval_start;
	logic i_power_state_request_n, o_low_power_state, o_diode_emulation_mode, o_low_side_drive_reduction;
	int n_mismatch = 0, samples_checked = 0, cyc = 0;
	always #2 i_clk = ~i_clk;
	mps_sequencer #(.RST_HOLD_CYC(20)) dut (.*);
	mps_far_model far (.i_clk(i_clk), .i_want_low(want_low), .i_low_side_gate(o_low_side_gate),
		.o_request_n(i_power_state_request_n), .o_zero_current(i_zero_current));
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// a hang counts as a mismatch
	always @(posedge i_clk) if (++cyc > 4000) begin n_mismatch++; conclude(); end
	task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin n_mismatch++; $display("Error %s expected %h seen %h", nm, exp, got); end
	endtask
	task automatic tick(int n); repeat (n) @(posedge i_clk); #1; endtask
	task automatic boot(logic strap);
		i_arst_n = 0; i_soft_start_busy = 1; i_phase_three_sense_neg = strap;
		tick(8); i_arst_n = 1; tick(4); i_soft_start_busy = 0; tick(260);
	endtask
	task automatic gap(int b, int exp);
		int n = 0;
		while (o_interval_start[0] !== 1'b1) tick(1);
		do begin tick(1); n++; end while (o_interval_start[b] !== 1'b1 && n < 40);
		chk("interval gap", exp, n);
	endtask
	task automatic ph0(logic [2:0] exp);
		chk("phase0 pulse and gates", exp, {o_pwm[0], o_high_side_gate[0], o_low_side_gate[0]});
	endtask
	initial begin
		boot(0);
		gap(1, 4);
		gap(2, 8);
		gap(0, 12);
		while (o_interval_start[0] !== 1'b1) tick(1);
		i_cmp_above = 3'h1; tick(3);
		ph0(3'b110);
		i_cmp_above = 3'h0; tick(3);
		ph0(3'b001);
		i_cmp_above = 3'h1; tick(3);
		ph0(3'b001);
		tick(6);
		ph0(3'b110);
		i_cmp_above = 3'h0; i_transient_all_phase_trip = 1; tick(3);
		chk("trip pulse", 3'h7, o_pwm);
		i_transient_all_phase_trip = 0; want_low = 1; tick(5);
		chk("low power", 3'h7, {o_low_power_state, o_diode_emulation_mode, o_low_side_drive_reduction});
		tick(5);
		chk("dem gates", 2'b00, {o_high_side_gate[0], o_low_side_gate[0]});
		i_transient_all_phase_trip = 1; tick(3);
		chk("one phase trip", 3'h1, o_pwm);
		i_transient_all_phase_trip = 0; i_vid_transition_busy = 1; tick(3);
		chk("busy state", 0, o_low_power_state);
		i_vid_transition_busy = 0; tick(5);
		chk("after busy", 1, o_low_power_state);
		i_processor_reset_in_n = 0; tick(3);
		chk("cpu reset", 0, o_low_power_state);
		i_processor_reset_in_n = 1; tick(12);
		chk("hold wait", 0, o_low_power_state);
		tick(15);
		chk("hold done", 1, o_low_power_state);
		want_low = 0; tick(4);
		chk("restore", 0, {o_low_power_state, o_diode_emulation_mode});
		boot(1);
		gap(1, 6);
		i_transient_all_phase_trip = 1; tick(3);
		chk("two-phase trip", 3'h3, o_pwm);
		conclude();
	end
endmodule // multiphase_pwm_sequencer_tb_top
